// ---- design/autoneg_adv_defines.svh ----
// Notes on behaviour
// - Word 0x04, read/write, resets to zero.
// - SGMII bit 12 advertises full duplex.
// - SGMII bits 11:10 carry link speed code.
// - 1000BASE-X bit 15 is next page flag.
// - No local pages: answer null message pages.
// - 1000BASE-X bits 13:12 carry remote fault code.
// - 1000BASE-X pause ability field is writable.
// - Restart bit 9 pulses restart only when bit 12 is written one with it, self clears.
`ifndef AUTONEG_ADV_DEFINES_SVH
`define AUTONEG_ADV_DEFINES_SVH
`define CTRL_OFFSET     5'h00
`define STS_OFFSET      5'h01
`define ADV_OFFSET      5'h04
`define ADV_RESET       16'h0000
`define STS_BASE        16'h0149
`define CTRL_AN_EN      12
`define CTRL_RESTART    9
`define STS_AN_DONE     5
`define STS_LINK        2
`define SG_DUPLEX       12
`define SG_SPEED_HI     11
`define SG_SPEED_LO     10
`define SG_LOW_RESERVED_FIELD_HI      9
`define BX_NEXT_PAGE    15
`define BX_FAULT_HI     13
`define BX_FAULT_LO     12
`define BX_PAUSE_HI     8
`define BX_PAUSE_LO     7
`define NULL_MSG_CODE   11'h001
`define OP_WRITE        2'h1
`define OP_READ         2'h2
`define HDR_LAST        5'h0B
`define DATA_LAST       5'h0F
`endif

// ---- design/autoneg_adv_pkg.sv ----
package autoneg_adv_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_HEADER,
		ST_TURN,
		ST_DATA
	} mdio_state_e;

	typedef logic [15:0] word_t;
	typedef logic [1:0]  code2_t;
	typedef logic [10:0] msg_code_t;

	function automatic logic reg_hit(input logic [4:0] addr,
		input logic [4:0] offset);
		reg_hit = (addr == offset);
	endfunction
endpackage

// ---- design/adv_fields_if.sv ----
`timescale 1ns/1ns
interface adv_fields_if;
	import autoneg_adv_pkg::*;
	word_t     adv_word;
	logic      sgmii_mode;
	logic      lp_next_page;
	logic      local_np_avail;
	logic      full_duplex_flag;
	code2_t    link_speed_code;
	logic      next_page_flag;
	code2_t    remote_fault_code;
	code2_t    pause_ability_code;
	logic      send_null_page;
	msg_code_t null_msg_code;

	modport owner (
		output adv_word, sgmii_mode, lp_next_page, local_np_avail,
		input  full_duplex_flag, link_speed_code, next_page_flag,
		input  remote_fault_code, pause_ability_code, send_null_page,
		input  null_msg_code
	);
	modport decoder (
		input  adv_word, sgmii_mode, lp_next_page, local_np_avail,
		output full_duplex_flag, link_speed_code, next_page_flag,
		output remote_fault_code, pause_ability_code, send_null_page,
		output null_msg_code
	);
endinterface // adv_fields_if

// ---- design/adv_field_decode.sv ----
`timescale 1ns/1ns
`include "autoneg_adv_defines.svh"
module adv_field_decode (
	adv_fields_if.decoder f
);
	import autoneg_adv_pkg::*;

	wire sg = f.sgmii_mode;
	wire bx = ~f.sgmii_mode;

	// layout by mode
	// Fields of the inactive layout read as zero so a stale value cannot
	// leak into the advertisement after a mode change.
	// duplex flag
	assign f.full_duplex_flag = sg & f.adv_word[`SG_DUPLEX];
	assign f.link_speed_code = sg ?
		f.adv_word[`SG_SPEED_HI:`SG_SPEED_LO] : 2'h0;
	assign f.next_page_flag = bx & f.adv_word[`BX_NEXT_PAGE];
	assign f.remote_fault_code = bx ?
		f.adv_word[`BX_FAULT_HI:`BX_FAULT_LO] : 2'h0;
	assign f.pause_ability_code = bx ?
		f.adv_word[`BX_PAUSE_HI:`BX_PAUSE_LO] : 2'h0;
	assign f.send_null_page = f.next_page_flag & f.lp_next_page &
		~f.local_np_avail;
	assign f.null_msg_code = `NULL_MSG_CODE;
endmodule // adv_field_decode

// ---- design/autoneg_advertisement_reg.sv ----
`timescale 1ns/1ns
`include "autoneg_adv_defines.svh"
module autoneg_advertisement_reg (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       mdc,
	input  wire logic                       mdio_i,
	output logic                            mdio_o,
	output logic                            mdio_oe_n,
	input  wire logic [4:0]                 phy_addr,
	input  wire logic                       sgmii_mode,
	input  wire logic                       an_complete,
	input  wire logic                       link_up,
	input  wire logic                       lp_next_page,
	input  wire logic                       local_np_avail,
	output logic                            an_enable,
	output logic                            an_restart,
	output autoneg_adv_pkg::word_t          adv_word,
	output logic                            full_duplex_flag,
	output autoneg_adv_pkg::code2_t         link_speed_code,
	output logic                            next_page_flag,
	output autoneg_adv_pkg::code2_t         remote_fault_code,
	output autoneg_adv_pkg::code2_t         pause_ability_code,
	output logic                            send_null_page,
	output autoneg_adv_pkg::msg_code_t      null_msg_code
);
	import autoneg_adv_pkg::*;

	logic [2:0]  mdc_s_q;
	logic [2:0]  mdio_s_q;
	logic        mdc_f_q;
	logic        mdio_f_q;
	mdio_state_e state_q;
	logic [4:0]  cnt_q;
	logic [11:0] hdr_q;
	word_t       data_q;
	logic        sel_q;
	logic        rd_q;
	logic        out_q;
	logic        oe_n_q;
	word_t       adv_q;
	logic        an_en_q;
	logic        restart_q;

	// A pin level counts only once the second and third stages agree.
	wire mdc_agree  = (mdc_s_q[1] == mdc_s_q[2]);
	wire mdio_agree = (mdio_s_q[1] == mdio_s_q[2]);
	wire mdc_rise   = mdc_agree & mdc_s_q[2] & ~mdc_f_q;
	wire mdio_bit   = mdio_agree ? mdio_s_q[2] : mdio_f_q;

	wire [11:0] hdr_full = {hdr_q[10:0], mdio_bit};
	wire [1:0]  hdr_op   = hdr_full[11:10];
	wire [4:0]  hdr_phy  = hdr_full[9:5];
	wire [4:0]  hdr_reg  = hdr_full[4:0];
	wire        phy_ok   = (hdr_phy == phy_addr);
	wire        op_rd    = (hdr_op == `OP_READ);
	wire        op_wr    = (hdr_op == `OP_WRITE);
	logic [4:0] reg_q;

	// Counter end points and the read-drive condition of a frame.
	wire hdr_end  = (cnt_q == `HDR_LAST);
	wire data_end = (cnt_q == `DATA_LAST);
	wire ta_first = (cnt_q == 5'h00);
	wire drive_rd = sel_q & rd_q;

	// A write lands only on the rise that samples data bit 0, so the
	// register never holds a partly shifted word.
	wire   wr_en   = mdc_rise & (state_q == ST_DATA) &
		data_end & sel_q & ~rd_q;
	word_t wr_word;
	assign wr_word = {data_q[14:0], mdio_bit};
	wire   wr_adv  = wr_en & reg_hit(reg_q, `ADV_OFFSET);
	wire   wr_ctrl = wr_en & reg_hit(reg_q, `CTRL_OFFSET);

	word_t ctrl_rd;
	word_t sts_rd;
	word_t rd_word;
	assign ctrl_rd = an_en_q ? (16'h0001 << `CTRL_AN_EN) : 16'h0000;
	// Completion shows only while negotiation is enabled.
	assign sts_rd = `STS_BASE |
		({15'h0000, an_complete & an_en_q} << `STS_AN_DONE) |
		({15'h0000, link_up} << `STS_LINK);
	// Unmapped addresses read as zero.
	assign rd_word = reg_hit(hdr_reg, `ADV_OFFSET)  ? adv_q   :
		reg_hit(hdr_reg, `CTRL_OFFSET) ? ctrl_rd :
		reg_hit(hdr_reg, `STS_OFFSET)  ? sts_rd  : 16'h0000;

	always_ff @(posedge clk) begin
		if (srst) begin
			// Reset values match the idle pin levels, so neither a false
			// clock edge nor a false start bit follows the release.
			mdc_s_q  <= 3'h0;
			mdio_s_q <= 3'h7;
			mdc_f_q  <= 1'b0;
			mdio_f_q <= 1'b1;
		end else begin
			mdc_s_q  <= {mdc_s_q[1:0], mdc};
			mdio_s_q <= {mdio_s_q[1:0], mdio_i};
			mdc_f_q  <= mdc_agree ? mdc_s_q[2] : mdc_f_q;
			mdio_f_q <= mdio_bit;
		end
	end

	// Preamble is optional: a frame starts at the first zero seen idle.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 5'h00;
			hdr_q   <= 12'h000;
			reg_q   <= 5'h00;
			data_q  <= 16'h0000;
			sel_q   <= 1'b0;
			rd_q    <= 1'b0;
			out_q   <= 1'b1;
			oe_n_q  <= 1'b1;
		end else if (mdc_rise) begin
			case (state_q)
				ST_IDLE: begin
					oe_n_q <= 1'b1;
					if (!mdio_bit) begin
						state_q <= ST_START;
					end
				end
				ST_START: begin
					cnt_q   <= 5'h00;
					state_q <= mdio_bit ? ST_HEADER : ST_IDLE;
				end
				ST_HEADER: begin
					hdr_q <= hdr_full;
					cnt_q <= cnt_q + 5'h01;
					if (hdr_end) begin
						// Frames for other ports are followed but not answered.
						sel_q   <= phy_ok & (op_rd | op_wr);
						rd_q    <= op_rd;
						reg_q   <= hdr_reg;
						data_q  <= rd_word;
						cnt_q   <= 5'h00;
						state_q <= ST_TURN;
					end
				end
				ST_TURN: begin
					cnt_q <= cnt_q + 5'h01;
					// Driving starts after the first turnaround bit, so the
					// line shows a zero during the second one.
					if (drive_rd) begin
						oe_n_q <= 1'b0;
						out_q  <= ta_first ? 1'b0 : data_q[15];
					end
					if (!ta_first) begin
						if (rd_q) begin
							data_q <= {data_q[14:0], 1'b0};
						end
						cnt_q   <= 5'h00;
						state_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					cnt_q <= cnt_q + 5'h01;
					if (rd_q) begin
						out_q  <= data_q[15];
						data_q <= {data_q[14:0], 1'b0};
					end else begin
						data_q <= wr_word;
					end
					if (data_end) begin
						oe_n_q  <= 1'b1;
						out_q   <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			adv_q     <= `ADV_RESET;
			an_en_q   <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			if (wr_adv) begin
				adv_q <= wr_word;
			end
			if (wr_ctrl) begin
				an_en_q <= wr_word[`CTRL_AN_EN];
			end
			// The restart bit is never stored: it reads back as zero and
			// cannot fire again without a fresh write.
			// one-cycle restart
			restart_q <= wr_ctrl & wr_word[`CTRL_RESTART] &
				wr_word[`CTRL_AN_EN];
		end
	end

	// The raw word and the mode pin travel together to the decoder.
	adv_fields_if fields ();
	assign fields.adv_word       = adv_q;
	assign fields.sgmii_mode     = sgmii_mode;
	assign fields.lp_next_page   = lp_next_page;
	assign fields.local_np_avail = local_np_avail;

	adv_field_decode u_decode (
		.f (fields.decoder)
	);

	assign mdio_o             = out_q;
	assign mdio_oe_n          = oe_n_q;
	assign an_enable          = an_en_q;
	assign an_restart         = restart_q;
	assign adv_word           = adv_q;
	assign full_duplex_flag   = fields.full_duplex_flag;
	assign link_speed_code    = fields.link_speed_code;
	assign next_page_flag     = fields.next_page_flag;
	assign remote_fault_code  = fields.remote_fault_code;
	assign pause_ability_code = fields.pause_ability_code;
	assign send_null_page     = fields.send_null_page;
	assign null_msg_code      = fields.null_msg_code;
endmodule // autoneg_advertisement_reg

// ---- testbench/adv_sva.sv ----
`timescale 1ns/1ns
module adv_sva
	import autoneg_adv_pkg::*;
(
	input wire logic      clk,
	input wire logic      srst,
	input wire logic      mdio_oe_n,
	input wire logic      sgmii_mode,
	input wire logic      lp_next_page,
	input wire logic      local_np_avail,
	input wire logic      an_enable,
	input wire logic      an_restart,
	input wire word_t     adv_word,
	input wire logic      full_duplex_flag,
	input wire code2_t    link_speed_code,
	input wire logic      next_page_flag,
	input wire code2_t    remote_fault_code,
	input wire code2_t    pause_ability_code,
	input wire logic      send_null_page,
	input wire msg_code_t null_msg_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	rst_clear_a: assert property (disable iff (1'b0)
		srst |=> adv_word == 16'h0000 && !an_restart) else $error("reset");
	write_quiet_a: assert property (!$stable(adv_word) |-> mdio_oe_n)
		else $error("write while driving");
	fdx_decode_a: assert property (
		full_duplex_flag == (sgmii_mode && adv_word[12])) else $error("fdx");
	speed_decode_a: assert property (
		link_speed_code == (sgmii_mode ? adv_word[11:10] : 2'h0))
		else $error("speed");
	np_decode_a: assert property (
		next_page_flag == (!sgmii_mode && adv_word[15])) else $error("np");
	null_page_a: assert property (null_msg_code == 11'h001 &&
		send_null_page == (next_page_flag && lp_next_page && !local_np_avail))
		else $error("null page");
	fault_decode_a: assert property (
		remote_fault_code == (sgmii_mode ? 2'h0 : adv_word[13:12]))
		else $error("fault");
	pause_decode_a: assert property (
		pause_ability_code == (sgmii_mode ? 2'h0 : adv_word[8:7]))
		else $error("pause");
	restart_pulse_a: assert property (
		an_restart |-> an_enable ##1 !an_restart) else $error("restart");
endmodule // adv_sva

// ---- testbench/mdio_mgr.sv ----
`timescale 1ns/1ns
module mdio_mgr (
	input  wire logic clk,
	input  wire logic line,
	output logic      mdc,
	output logic      mdio_m
);
	initial begin
		mdc = 1'b0;
		mdio_m = 1'b1;
	end
	// Data moves with each fall, so it is settled long before each rise.
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
		input logic [15:0] wd, input int hp, output logic [15:0] rd);
		logic [31:0] f;
		f = {2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk);
			mdc <= 1'b0;
			mdio_m <= (op == 2'h2 && i < 18) ? 1'b1 : f[i];
			repeat (hp) @(posedge clk);
			mdc <= 1'b1;
			if (i < 16)
				rd[i] = line;
			repeat (hp) @(posedge clk);
		end
		@(posedge clk);
		mdc <= 1'b0;
		// Released line floats to its pull-up level between frames.
		mdio_m <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule // mdio_mgr

// ---- testbench/autoneg_advertisement_reg_tb.sv ----
`timescale 1ns/1ns
bind autoneg_advertisement_reg adv_sva chk_u (.clk, .srst, .mdio_oe_n,
	.sgmii_mode, .lp_next_page, .local_np_avail, .an_enable, .an_restart,
	.adv_word, .full_duplex_flag, .link_speed_code, .next_page_flag,
	.remote_fault_code, .pause_ability_code, .send_null_page,
	.null_msg_code);
module autoneg_advertisement_reg_tb;
	import autoneg_adv_pkg::*;
	localparam logic [4:0] PA = 5'h03;
	logic clk = 1'b0, srst = 1'b1, mdc, mdio_m, mdio_o, mdio_oe_n, line;
	logic sgmii_mode = 1'b1, an_complete = 1'b0, link_up = 1'b0;
	logic lp_next_page = 1'b0, local_np_avail = 1'b0, an_enable, an_restart;
	logic full_duplex_flag, next_page_flag, send_null_page;
	word_t     adv_word, w;
	code2_t    link_speed_code, remote_fault_code, pause_ability_code;
	msg_code_t null_msg_code;
	int        error_cnt = 0, n_checks = 0, pulses = 0, hp = 5;
	always #4 clk = ~clk;
	assign line = mdio_m & (mdio_oe_n | mdio_o);
	always @(posedge clk) if (an_restart === 1'b1) pulses <= pulses + 1;
	autoneg_advertisement_reg dut (.clk, .srst, .mdc, .mdio_i(line), .mdio_o,
		.mdio_oe_n, .phy_addr(PA), .sgmii_mode, .an_complete, .link_up,
		.lp_next_page, .local_np_avail, .an_enable, .an_restart, .adv_word,
		.full_duplex_flag, .link_speed_code, .next_page_flag,
		.remote_fault_code, .pause_ability_code, .send_null_page,
		.null_msg_code);
	mdio_mgr mgr (.clk, .line, .mdc, .mdio_m);
	task automatic chk(input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [4:0] pa, ra, input logic [15:0] d);
		logic [15:0] x;
		mgr.frame(2'h1, pa, ra, d, hp, x);
	endtask
	task automatic rd(input logic [4:0] ra, input logic [15:0] e);
		logic [15:0] x;
		mgr.frame(2'h2, PA, ra, 16'h0000, hp, x);
		chk(x, e);
	endtask
	function automatic logic [15:0] exp_f(input logic [15:0] v);
		logic s, np;
		s = sgmii_mode;
		np = !s && v[15];
		return {7'h00, s && v[12], s ? v[11:10] : 2'h0, np,
			s ? 2'h0 : v[13:12], s ? 2'h0 : v[8:7],
			np && lp_next_page && !local_np_avail};
	endfunction
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'h4D4D9561));
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		rd(5'h04, 16'h0000);
		an_complete <= 1'b1;
		rd(5'h01, 16'h0149);
		rd(5'h1F, 16'h0000);
		sgmii_mode <= 1'b0;
		wr(PA, 5'h04, 16'h2000);
		wr(PA, 5'h00, 16'h0200);
		chk(16'(pulses), 16'h0000);
		wr(PA, 5'h00, 16'h1200);
		chk(16'(pulses), 16'h0001);
		chk(16'(remote_fault_code), 16'h0002);
		rd(5'h00, 16'h1000);
		for (int k = 0; k < 12; k++) begin
			{sgmii_mode, lp_next_page, local_np_avail, an_complete, link_up}
				<= 5'($urandom);
			hp = k[0] ? 9 : 5;
			w = k == 0 ? 16'hFFFF : 16'($urandom);
			if (k[1])
				w[9:0] = 10'h001;
			wr(PA, 5'h04, w);
			wr(PA + 5'h01, 5'h04, ~w);
			rd(5'h04, w);
			chk(adv_word, w);
			chk(exp_f(w), 16'({full_duplex_flag, link_speed_code,
				next_page_flag, remote_fault_code, pause_ability_code,
				send_null_page}));
			chk(16'(null_msg_code), 16'h0001);
			rd(5'h01, {10'h005, an_complete, 2'h1, link_up, 2'h1});
		end
		sgmii_mode <= 1'b0;
		lp_next_page <= 1'b1;
		local_np_avail <= 1'b0;
		wr(PA, 5'h04, 16'h3180);
		chk(16'({next_page_flag, send_null_page}), 16'h0000);
		chk(16'({remote_fault_code, pause_ability_code}), 16'h000F);
		wr(PA, 5'h04, 16'h8000);
		chk(16'(send_null_page), 16'h0001);
		// Refused opcode, then a read meant for another port.
		mgr.frame(2'h3, PA, 5'h04, 16'h0000, hp, w);
		mgr.frame(2'h2, PA + 5'h01, 5'h04, 16'h0000, hp, w);
		chk(w, 16'hFFFF);
		rd(5'h04, 16'h8000);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		rd(5'h04, 16'h0000);
		chk(16'(an_enable), 16'h0000);
		an_complete <= 1'b1;
		link_up <= 1'b0;
		rd(5'h01, 16'h0149);
		print_verdict;
	end
endmodule // autoneg_advertisement_reg_tb
